// *** amcc_pkg.sv ***
package amcc_pkg;
  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] AMCC_MODE_ADDR = 12'h004; // Mode control.
  localparam logic [11:0] AMCC_CHAN_ADDR = 12'h008; // Channel scan.
  localparam logic [11:0] AMCC_IRQS_ADDR = 12'h080; // Irq status.
  localparam logic [11:0] AMCC_IRQM_ADDR = 12'h084; // Irq mask.

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int AMCC_DONE_BIT = 7; // Completion flag.
  localparam int AMCC_BUSY_BIT = 6; // Busy flag.
  localparam int AMCC_ITM_LSB = 3; // Interval field low bit.
  localparam int AMCC_RPT_BIT = 2; // Repeat bit.
  localparam int AMCC_SCAN_BIT = 1; // Scan bit.
  localparam int AMCC_START_BIT = 0; // Start bit.
  localparam int AMCC_VREF_BIT = 7; // Reference enable.
  localparam int AMCC_IDLE_BIT = 6; // Idle run enable.
  localparam int AMCC_WID_LSB = 4; // Scan width low bit.
  localparam int AMCC_CH_LSB = 0; // Channel field low bit.

  // ---------------------------------------------------------------
  // Codes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] AMCC_ITM_1 = 2'h0; // Every conversion.
  localparam logic [1:0] AMCC_ITM_4 = 2'h1; // Every 4.
  localparam logic [1:0] AMCC_ITM_8 = 2'h2; // Every 8.
  localparam logic [2:0] AMCC_CNT_4 = 3'h3; // Last count of 4.
  localparam logic [2:0] AMCC_CNT_8 = 3'h7; // Last count of 8.
  localparam logic [1:0] AMCC_WID_4 = 2'h0; // 4-channel scan.
  localparam logic [1:0] AMCC_WID_8 = 2'h1; // 8-channel scan.
  localparam logic [1:0] AMCC_WID_12 = 2'h2; // 12-channel scan.
  localparam logic [3:0] AMCC_CH_MAX12 = 4'hB; // Top of 12 scan.
  localparam logic [7:0] AMCC_RST8 = 8'h00; // Register reset.
  localparam logic [31:0] AMCC_ZERO32 = 32'h0000_0000;

  // Sequencer states.
  typedef enum logic [1:0] {
    AMCC_ST_IDLE = 2'b00,
    AMCC_ST_REQ = 2'b01,
    AMCC_ST_WAIT = 2'b10
  } amcc_state_t;
endpackage

// *** amcc_scan_range.sv ***
`timescale 1ns/10ps
module amcc_scan_range
  import amcc_pkg::*;
(
  // Mode inputs.
  input wire logic scan,
  input wire logic [1:0] width,
  input wire logic [3:0] chan,
  // Channel range.
  output logic [3:0] first_ch,
  output logic [3:0] last_ch
);
  // ---------------------------------------------------------------
  // Range decode
  // ---------------------------------------------------------------
  // Turns the mode fields into the first and last input of a pass.
  always_comb begin
    first_ch = 4'h0;
    last_ch = chan;
    if (!scan) begin
      // A fixed channel is a pass of one input.
      first_ch = chan;
      last_ch = chan;
    end else begin
      case (width)
        AMCC_WID_4: begin
          // Top bit ignored; bit 2 picks the lower or upper group.
          first_ch = {2'b00, chan[2], 1'b0} << 1;
          last_ch = {1'b0, chan[2:0]};
        end
        AMCC_WID_8: begin
          // Codes above seven fold onto the low three bits.
          last_ch = {1'b0, chan[2:0]};
        end
        AMCC_WID_12: begin
          // Undefined codes are clamped so the scan stays in range.
          last_ch = (chan > AMCC_CH_MAX12) ? AMCC_CH_MAX12 : chan;
        end
        default: begin
          // Reserved width behaves as a 4-channel scan.
          first_ch = {2'b00, chan[2], 1'b0} << 1;
          last_ch = {1'b0, chan[2:0]};
        end
      endcase
    end
  end
endmodule

// *** amcc_top.sv ***
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps
// Function
// - Done flag sets on completion, clears on read.
// - Busy flag high while converting.
// - Interval field gives 1, 4, 8 conversions.
// - Interval applies only in fixed repeat.
// - Repeat bit restarts conversions continuously.
// - Scan bit selects channel sequence.
// - Writing one to start begins conversion.
// - Reference enable bit drives reference output.
// - Idle run bit allows conversion in idle.
// - Scan width field selects 4/8/12.
// - Fixed mode converts channel field input.
// - 4-channel scan groups by bit two.
// - 8-channel scan uses low three bits.
// - 12-channel scan stops at the channel field input, clamped to eleven.
module amcc_top
  import amcc_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Conversion core.
  input wire logic core_done,
  input wire logic idle_mode,
  output logic conv_req,
  output logic [3:0] conv_chan,
  output logic ref_enable,
  // Events.
  output logic done_pulse,
  output logic irq
);
  import amcc_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [4:1] mode_q; // Interval, repeat and scan settings; start is never stored.
  logic [7:0] chan_q; // Channel scan control.
  logic done_q; // Completion flag.
  logic busy_q; // Busy flag.
  logic irqs_q; // Sticky status bit.
  logic irqm_q; // Mask bit.
  logic irq_q; // Interrupt output register.
  logic pready_q; // Access answer.
  logic pslverr_q; // Unmapped answer.
  logic [31:0] prdata_q; // Read data.
  logic req_q; // Conversion request pulse.
  logic [3:0] cur_q; // Channel being converted.
  logic [2:0] dec_q; // Decimation count.
  logic dpulse_q; // Completion event pulse.
  amcc_state_t st_q; // Sequencer state.
  amcc_state_t st_d; // Next sequencer state.
  logic [3:0] first_ch; // Pass start.
  logic [3:0] last_ch; // Pass end.
  logic acc; // Access phase without answer yet.
  logic wr_en; // Write takes effect.
  logic rd_en; // Read completes.
  logic mapped; // Address decodes.
  logic start; // Start command.
  logic pass_end; // Last channel of the pass converted.
  logic fix_rpt; // Fixed-channel repeat mode.
  logic report; // Completion to report.
  logic halt; // Held off by idle.

  // ---------------------------------------------------------------
  // Scan range
  // ---------------------------------------------------------------
  amcc_scan_range u_range (
    .scan(mode_q[AMCC_SCAN_BIT]),
    .width(chan_q[AMCC_WID_LSB+1:AMCC_WID_LSB]),
    .chan(chan_q[AMCC_CH_LSB+3:AMCC_CH_LSB]),
    .first_ch(first_ch),
    .last_ch(last_ch)
  );

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // One wait state: the answer is built while pready is low.
  assign acc = psel & penable & ~pready_q;
  assign wr_en = psel & penable & pready_q & pwrite;
  assign rd_en = psel & penable & pready_q & ~pwrite;
  assign mapped = (paddr == AMCC_MODE_ADDR) || (paddr == AMCC_CHAN_ADDR) ||
                  (paddr == AMCC_IRQS_ADDR) || (paddr == AMCC_IRQM_ADDR);
  // A start is a one in the start bit; zero does nothing.
  assign start = wr_en && (paddr == AMCC_MODE_ADDR) && pwdata[AMCC_START_BIT];
  assign fix_rpt = mode_q[AMCC_RPT_BIT] & ~mode_q[AMCC_SCAN_BIT];
  assign pass_end = (st_q == AMCC_ST_WAIT) && core_done && (cur_q == last_ch);
  // Conversion is halted in idle unless allowed to run there.
  assign halt = idle_mode & ~chan_q[AMCC_IDLE_BIT];

  // Decimation only shortens reports in fixed repeat mode.
  always_comb begin
    report = pass_end;
    if (pass_end && fix_rpt) begin
      case (mode_q[AMCC_ITM_LSB+1:AMCC_ITM_LSB])
        AMCC_ITM_1: report = 1'b1;
        AMCC_ITM_4: report = (dec_q == AMCC_CNT_4);
        AMCC_ITM_8: report = (dec_q == AMCC_CNT_8);
        default: report = 1'b1;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------
  // Ready and error come from flops so outputs stay glitch free.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= acc;
      pslverr_q <= acc & ~mapped;
    end
  end

  // Read data is sampled one cycle before the answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= AMCC_ZERO32;
    end else if (acc && !pwrite) begin
      prdata_q <= AMCC_ZERO32;
      case (paddr)
        AMCC_MODE_ADDR: begin
          // Start reads as zero; upper bits read as zero.
          prdata_q[AMCC_DONE_BIT] <= done_q | report;
          prdata_q[AMCC_BUSY_BIT] <= busy_q;
          prdata_q[4:1] <= mode_q[4:1];
        end
        AMCC_CHAN_ADDR: prdata_q[7:0] <= chan_q;
        AMCC_IRQS_ADDR: prdata_q[0] <= irqs_q;
        AMCC_IRQM_ADDR: prdata_q[0] <= irqm_q;
        default: prdata_q <= AMCC_ZERO32;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Mode fields: software must set them before the start bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= AMCC_RST8[4:1];
    end else if (wr_en && paddr == AMCC_MODE_ADDR) begin
      mode_q <= pwdata[4:1];
    end
  end

  // Channel control, reference and idle settings.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_q <= AMCC_RST8;
    end else if (wr_en && paddr == AMCC_CHAN_ADDR) begin
      chan_q <= pwdata[7:0];
    end
  end

  // Reference follows its bit; settle time is software's wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_enable <= 1'b0;
    end else begin
      ref_enable <= chan_q[AMCC_VREF_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Next state: a start always restarts from the first channel.
  always_comb begin
    st_d = st_q;
    case (st_q)
      AMCC_ST_IDLE: begin
        if (start) st_d = AMCC_ST_REQ;
      end
      AMCC_ST_REQ: begin
        if (!halt && !start) st_d = AMCC_ST_WAIT;
      end
      AMCC_ST_WAIT: begin
        if (start) begin
          st_d = AMCC_ST_REQ;
        end else if (core_done) begin
          // A single pass stops; repeat starts over.
          if (pass_end && !mode_q[AMCC_RPT_BIT]) st_d = AMCC_ST_IDLE;
          else st_d = AMCC_ST_REQ;
        end
      end
      default: st_d = AMCC_ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_q <= AMCC_ST_IDLE;
    else st_q <= st_d;
  end

  // Channel pointer walks from first to last within a pass.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_q <= 4'h0;
    end else if (start || pass_end) begin
      cur_q <= first_ch;
    end else if (st_q == AMCC_ST_WAIT && core_done) begin
      cur_q <= cur_q + 4'h1;
    end
  end

  // Request pulse and channel to the core.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= 1'b0;
      conv_chan <= 4'h0;
    end else begin
      req_q <= (st_q == AMCC_ST_REQ) && !halt && !start;
      if (st_q == AMCC_ST_REQ) conv_chan <= cur_q;
    end
  end

  // Busy from start until a single pass ends.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_q <= 1'b0;
    else busy_q <= (st_d != AMCC_ST_IDLE);
  end

  // Decimation counter counts passes in fixed repeat mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_q <= 3'h0;
    end else if (start) begin
      dec_q <= 3'h0;
    end else if (pass_end && fix_rpt) begin
      dec_q <= report ? 3'h0 : dec_q + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // Flags and interrupt
  // ---------------------------------------------------------------
  // Completion flag: a new completion wins over the read clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else if (report) begin
      done_q <= 1'b1;
    end else if (start || (rd_en && paddr == AMCC_MODE_ADDR)) begin
      done_q <= 1'b0;
    end
  end

  // Event pulse on the same edge as the flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dpulse_q <= 1'b0;
    else dpulse_q <= report;
  end

  // Sticky status, cleared by writing one; set wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqs_q <= 1'b0;
    end else if (report) begin
      irqs_q <= 1'b1;
    end else if (wr_en && paddr == AMCC_IRQS_ADDR && pwdata[0]) begin
      irqs_q <= 1'b0;
    end
  end

  // Mask register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irqm_q <= 1'b0;
    else if (wr_en && paddr == AMCC_IRQM_ADDR) irqm_q <= pwdata[0];
  end

  // Level interrupt.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_q <= 1'b0;
    else irq_q <= irqs_q & irqm_q;
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign conv_req = req_q;
  assign done_pulse = dpulse_q;
  assign irq = irq_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_done_set;
    @(posedge pclk) disable iff (!presetn) report |=> done_q && dpulse_q;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_done_clr;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && paddr == AMCC_MODE_ADDR && !report) |=> !done_q;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done not cleared by read");

  property p_busy;
    @(posedge pclk) disable iff (!presetn) start |=> busy_q;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not set on start");

  property p_dec8;
    @(posedge pclk) disable iff (!presetn)
      (pass_end && fix_rpt && mode_q[4:3] == AMCC_ITM_8 && dec_q != AMCC_CNT_8) |=> !dpulse_q;
  endproperty
  a_dec8: assert property (p_dec8) else $error("early report in 8 mode");

  property p_nodec;
    @(posedge pclk) disable iff (!presetn) (pass_end && !fix_rpt) |=> dpulse_q;
  endproperty
  a_nodec: assert property (p_nodec) else $error("report lost outside fixed repeat");

  property p_single;
    @(posedge pclk) disable iff (!presetn)
      (pass_end && !mode_q[AMCC_RPT_BIT] && !start) |=> ##1 !busy_q;
  endproperty
  a_single: assert property (p_single) else $error("single pass did not stop");

  property p_req;
    @(posedge pclk) disable iff (!presetn) (start && !halt) |-> ##[1:3] req_q;
  endproperty
  a_req: assert property (p_req) else $error("no request after start");

  property p_ref;
    @(posedge pclk) disable iff (!presetn) ##1 (ref_enable == $past(chan_q[AMCC_VREF_BIT]));
  endproperty
  a_ref: assert property (p_ref) else $error("reference not following bit");

  property p_idle;
    @(posedge pclk) disable iff (!presetn) halt |=> !req_q;
  endproperty
  a_idle: assert property (p_idle) else $error("request while idle halted");

  property p_range;
    @(posedge pclk) disable iff (!presetn)
      (req_q && mode_q[AMCC_SCAN_BIT] && chan_q[5:4] == AMCC_WID_12) |-> conv_chan <= AMCC_CH_MAX12;
  endproperty
  a_range: assert property (p_range) else $error("12 scan beyond eleven");
endmodule

// *** amcc_core_model.sv ***
`timescale 1ns/10ps
module amcc_core_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Request from the control block and the answer delay.
  input wire logic conv_req,
  input wire logic [7:0] lat,
  // Completion back to the control block.
  output logic core_done
);
  logic busy_q; // A conversion is under way.
  logic [7:0] cnt_q; // Cycles left before the answer.

  // One conversion per request; the delay is set by the bench so that both quick and slow cores are seen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      core_done <= 1'b0;
    end else begin
      core_done <= 1'b0;
      if (conv_req) begin
        busy_q <= 1'b1;
        cnt_q <= lat;
      end else if (busy_q) begin
        // The pulse lasts one cycle so that a slow reader cannot count it twice.
        if (cnt_q == 8'h00) begin
          busy_q <= 1'b0;
          core_done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end
endmodule

// *** tb.sv ***
`timescale 1ns/10ps
module tb
  import amcc_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic core_done, idle_mode, conv_req, ref_enable, done_pulse, irq;
  logic [3:0] conv_chan;
  logic [7:0] lat;
  int bad_count = 0;
  int n_tests = 0;
  int n_req; // Requests seen since the last clear.
  logic [3:0] q_ch[$]; // Channels requested, in order.
  int done_at[$]; // Request count at each done pulse.

  always #12.5 pclk = ~pclk;

  amcc_top amcc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_done(core_done),
    .idle_mode(idle_mode), .conv_req(conv_req), .conv_chan(conv_chan), .ref_enable(ref_enable),
    .done_pulse(done_pulse), .irq(irq));
  amcc_core_model amcc_core_model_inst (.pclk(pclk), .presetn(presetn), .conv_req(conv_req), .lat(lat),
    .core_done(core_done));

  // Monitor: records each channel the core is asked for and the request count at each done pulse.
  always @(posedge pclk) begin
    if (done_pulse === 1'b1) done_at.push_back(n_req);
    if (conv_req === 1'b1) begin
      q_ch.push_back(conv_chan);
      n_req++;
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      bad_count++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    chk(nm, rd, exp);
  endtask

  // Bounded wait for n done pulses; running out counts as a failure.
  task automatic wait_done(input int n);
    for (int i = 0; i < 2000 && done_at.size() < n; i++) @(posedge pclk);
    if (done_at.size() < n) begin
      bad_count++;
      summarize();
    end
  endtask

  task automatic clr();
    q_ch.delete();
    done_at.delete();
    n_req = 0;
    lat <= 8'(6 + $urandom_range(7, 0));
  endtask

  // Writes the channel register, then the mode, then the start bit.
  task automatic arm(input int sc, input int md, input logic [7:0] chan);
    clr();
    wr(AMCC_CHAN_ADDR, {24'h0, chan});
    wr(AMCC_MODE_ADDR, 32'(md | (sc << 1)));
    wr(AMCC_MODE_ADDR, 32'(md | (sc << 1) | 1));
  endtask

  // Single pass; the expected channel range is worked out independently here.
  task automatic run_pass(input int sc, input int wd, input int ch, input int idl);
    int f, l;
    if (sc == 0) begin f = ch; l = ch; end
    else if (wd == 1) begin f = 0; l = ch % 8; end
    else if (wd == 2) begin f = 0; l = (ch > 11) ? 11 : ch; end
    else begin f = ch & 4; l = ch & 7; end
    arm(sc, 0, 8'(8'h80 | (idl << 6) | (wd << 4) | ch));
    rdc("busy", AMCC_MODE_ADDR, 32'(8'h40 | (sc << 1)));
    wait_done(1);
    chk("pass length", q_ch.size(), l - f + 1);
    for (int k = f; k <= l; k++) chk("channel", {28'h0, q_ch[k - f]}, k);
    chk("done pulses", done_at.size(), 1);
    rdc("done set", AMCC_MODE_ADDR, 32'(8'h80 | (sc << 1)));
    rdc("done cleared", AMCC_MODE_ADDR, 32'(sc << 1));
  endtask

  // Repeat run: n conversions between done pulses, then stop by clearing repeat.
  task automatic run_rep(input int sc, input int irq_interval_sel, input int n);
    logic [31:0] rd;
    logic e;
    int k;
    arm(sc, (irq_interval_sel << 3) | 4, 8'h81);
    wait_done(2);
    chk("first event", done_at[0], n);
    chk("second event", done_at[1], 2 * n);
    wr(AMCC_MODE_ADDR, 32'((irq_interval_sel << 3) | (sc << 1)));
    repeat (60) @(posedge pclk);
    k = q_ch.size();
    repeat (60) @(posedge pclk);
    chk("repeat stopped", q_ch.size(), k);
    apb(1'b0, AMCC_MODE_ADDR, 32'h0, rd, e);
    chk("mode after stop", rd & 32'h5F, 32'((irq_interval_sel << 3) | (sc << 1)));
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  // The last entry uses the reserved width, which must act as a 4-channel scan.
  int tsc[11] = '{0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1};
  int twd[11] = '{0, 0, 0, 0, 0, 0, 1, 1, 2, 2, 3};
  int tch[11] = '{0, 0, 0, 3, 6, 14, 5, 15, 11, 8, 13};

  initial begin
    logic [31:0] rd;
    logic e;
    presetn = 1'b0;
    {psel, penable, pwrite, idle_mode} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lat = 8'h06;
    n_req = $urandom(13578);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc("mode reset", AMCC_MODE_ADDR, AMCC_ZERO32);
    rdc("chan reset", AMCC_CHAN_ADDR, AMCC_ZERO32);
    apb(1'b0, 12'h00C, 32'h0, rd, e);
    chk("unmapped error", {31'h0, e}, 32'h1);
    wr(AMCC_CHAN_ADDR, 32'h80);
    // The register takes the write at the answer edge and the output follows one edge later.
    repeat (2) @(posedge pclk);
    chk("reference on", {31'h0, ref_enable}, 32'h1);
    repeat (120) @(posedge pclk);
    // Writing zero to the start bit must not begin anything.
    clr();
    wr(AMCC_MODE_ADDR, 32'h0);
    repeat (20) @(posedge pclk);
    chk("no start", q_ch.size(), 0);
    for (int i = 0; i < 11; i++) begin
      if (tsc[i] == 0) tch[i] = $urandom_range(15, 0);
      run_pass(tsc[i], twd[i], tch[i], 0);
    end
    // Status stays set while masked; the mask lets it out, a one clears it.
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(AMCC_IRQM_ADDR, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    wr(AMCC_IRQS_ADDR, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    run_rep(0, 0, 1);
    run_rep(0, 1, 4);
    run_rep(0, 2, 8);
    run_rep(1, 2, 2);
    // Idle with the run bit set keeps going; with it clear the core is held.
    idle_mode <= 1'b1;
    run_pass(0, 0, 9, 1);
    arm(0, 0, 8'h82);
    repeat (40) @(posedge pclk);
    chk("idle halt", q_ch.size(), 0);
    idle_mode <= 1'b0;
    wait_done(1);
    chk("idle resume", {28'h0, q_ch[0]}, 32'h2);
    wr(AMCC_CHAN_ADDR, 32'h0);
    repeat (2) @(posedge pclk);
    chk("reference off", {31'h0, ref_enable}, 32'h0);
    summarize();
  end

  // Hard limit on the whole run.
  initial begin
    #1000000;
    bad_count++;
    summarize();
  end
endmodule
